// >>> cod_defs.vh
// register offsets, field positions, reset values and codes for the clock output config bank
`ifndef COD_DEFS_VH
`define COD_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define COD_ADDR_DIV_CTRL 5'h00
`define COD_ADDR_DRV_EN 5'h04
`define COD_ADDR_DRV_TYPE 5'h08
`define COD_ADDR_DRV_AMP 5'h0c
`define COD_ADDR_STATUS 5'h10

// ----------------------------------------
// reset values
// ----------------------------------------
`define COD_RST_DIV_CTRL 16'h8069
`define COD_RST_DRV_EN 8'h00
`define COD_RST_DRV_TYPE 8'h6c
`define COD_RST_DRV_AMP 8'hb4

// ----------------------------------------
// masks of writable bits
// ----------------------------------------
`define COD_WMASK_DIV_CTRL 16'hbfff
`define COD_WMASK_DRV_EN 8'h0f
`define COD_WMASK_DRV_TYPE 8'hff
`define COD_WMASK_DRV_AMP 8'hff

// ----------------------------------------
// field positions
// ----------------------------------------
`define COD_DIV_REG_ON_BIT 15
`define COD_DIV_RATIO_MSB 13
`define COD_DRV_DIS_STATE_MSB 3
`define COD_DRV_DIS_STATE_LSB 2
`define COD_DRV_DISABLE_BIT 1
`define COD_DRV_PD_BIT 0
`define COD_CMOS_MSB 7
`define COD_CMOS_LSB 6
`define COD_CM_MSB 5
`define COD_CM_LSB 4
`define COD_TERM_BIT 3
`define COD_BIAS_BIT 2
`define COD_TYPE_MSB 1
`define COD_TYPE_LSB 0
`define COD_SWING_MSB 7
`define COD_SWING_LSB 4
`define COD_LVDS_AMP_BIT 3

// ----------------------------------------
// codes
// ----------------------------------------
`define COD_DIV_MIN 14'h000a
`define COD_TYPE_HCSL 2'h0
`define COD_TYPE_RSVD 2'h1
`define COD_TYPE_LVDS 2'h2
`define COD_TYPE_CMOS 2'h3
`define COD_DIS_LOW_LOW 2'h0
`define COD_DIS_LOW_HIGH 2'h1
`define COD_DIS_HIZ 2'h2
`define COD_DIS_RUN 2'h3
`define COD_CMOS_SAME 2'h0
`define COD_CMOS_OPP 2'h1
`define COD_CMOS_TRUE 2'h2
`define COD_CMOS_COMP 2'h3

`endif

// >>> cod_divider.v
// output clock divider with regulator gate
`timescale 1ns/1ps
module cod_divider #(
	parameter RATIO_W = 14
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// control
	input wire regulator_on_i,
	input wire [RATIO_W-1:0] ratio_i,
	// divided clock
	output reg div_clk_o
);
	reg [RATIO_W-1:0] cnt_q;
	wire [RATIO_W-1:0] half;
	assign half = {1'b0, ratio_i[RATIO_W-1:1]};

	always @(posedge clk_i) begin
		if (rst_i || !regulator_on_i) begin
			cnt_q <= {RATIO_W{1'b0}};
			div_clk_o <= 1'b0;
		end else if (cnt_q >= ratio_i - {{(RATIO_W-1){1'b0}}, 1'b1}) begin
			cnt_q <= {RATIO_W{1'b0}};
			div_clk_o <= 1'b0;
		end else begin
			cnt_q <= cnt_q + {{(RATIO_W-1){1'b0}}, 1'b1};
			div_clk_o <= (cnt_q + {{(RATIO_W-1){1'b0}}, 1'b1}) >= half;
		end
	end
endmodule

// >>> cod_pin_mux.v
// pin pair selection for driver type, disabled state and power down
`include "cod_defs.vh"
`timescale 1ns/1ps
module cod_pin_mux (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// controls
	input wire clk_in_i,
	input wire enabled_i,
	input wire power_down_i,
	input wire [1:0] drv_type_i,
	input wire [1:0] dis_state_i,
	input wire [1:0] cmos_arr_i,
	// pins
	output reg true_o,
	output reg true_oe_o,
	output reg comp_o,
	output reg comp_oe_o
);
	reg t_d;
	reg c_d;
	reg oe_d;

	always @* begin
		t_d = clk_in_i;
		c_d = ~clk_in_i;
		oe_d = 1'b1;
		if (power_down_i) begin
			t_d = 1'b0;
			c_d = 1'b0;
			oe_d = 1'b0;
		end else if (!enabled_i && dis_state_i != `COD_DIS_RUN) begin
			case (dis_state_i)
				`COD_DIS_LOW_LOW: begin
					t_d = 1'b0;
					c_d = (drv_type_i == `COD_TYPE_LVDS);
				end
				`COD_DIS_LOW_HIGH: begin
					t_d = 1'b0;
					c_d = 1'b1;
				end
				default: begin
					t_d = 1'b0;
					c_d = 1'b0;
					oe_d = 1'b0;
				end
			endcase
		end else if (drv_type_i == `COD_TYPE_CMOS) begin
			case (cmos_arr_i)
				`COD_CMOS_SAME: c_d = clk_in_i;
				`COD_CMOS_OPP: c_d = ~clk_in_i;
				`COD_CMOS_TRUE: c_d = 1'b0;
				default: begin
					t_d = 1'b0;
					c_d = ~clk_in_i;
				end
			endcase
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			true_o <= 1'b0;
			comp_o <= 1'b0;
			true_oe_o <= 1'b0;
			comp_oe_o <= 1'b0;
		end else begin
			true_o <= t_d;
			comp_o <= c_d;
			true_oe_o <= oe_d;
			comp_oe_o <= oe_d;
		end
	end
endmodule

// >>> cod_top.v
// clock output driver configuration bank with wishbone slave
// Behaviour
// RULE_01: fourteen bit divider ratio, minimum ten
// RULE_02: bit fifteen enables divider regulator, reset set
// RULE_03: disabled state field sets pin pair
// RULE_04: disable bit forces driver disabled
// RULE_05: power down tristates pins, overrides enables
// RULE_06: cmos arrangement field picks pin phases
// RULE_07: lvds common mode 700 to 1000 mV
// RULE_08: termination bit enables internal fifty ohm
// RULE_09: bias enable powers driver bias, reset set
// RULE_10: driver type hcsl, lvds, cmos; one reserved
// RULE_11: four bit swing, 200 to 900 mV
// RULE_12: lvds amplitude bit, 350 or 400 mV
// RULE_13: software keeps reserved fields at reset values
//
// Implementation choices: the Wishbone register port and the address map.
`include "cod_defs.vh"
`timescale 1ns/1ps
module cod_top (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [4:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	output reg err_o,
	// external disable source
	input wire ext_disable_i,
	// output pins
	output reg clk_out_true_o,
	output reg clk_out_true_oe_o,
	output reg clk_out_comp_o,
	output reg clk_out_comp_oe_o,
	// analog controls
	output reg divider_regulator_on_o,
	output reg driver_bias_on_o,
	output reg hcsl_term_on_o,
	output reg [1:0] low_swing_common_level_o,
	output reg [3:0] swing_code_o,
	output reg lvds_amp_high_o,
	output reg driver_power_down_o
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	localparam [15:0] DIV_WMASK = `COD_WMASK_DIV_CTRL;
	reg [15:0] div_ctrl_q;
	reg [7:0] drv_en_q;
	reg [7:0] drv_type_q;
	reg [7:0] drv_amp_q;
	reg ext_meta_q;
	reg ext_sync_q;
	reg [31:0] rdata_d;
	reg hit_d;
	wire req;
	wire div_clk;
	wire pin_t;
	wire pin_t_oe;
	wire pin_c;
	wire pin_c_oe;
	wire enabled;
	wire ratio_bad;
	wire type_bad;
	wire [13:0] ratio_eff;

	assign req = cyc_i && stb_i && !ack_o && !err_o;

	// ----------------------------------------
	// external disable synchroniser
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
		end else begin
			ext_meta_q <= ext_disable_i;
			ext_sync_q <= ext_meta_q;
		end
	end

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	always @* begin
		rdata_d = 32'h00000000;
		hit_d = 1'b1;
		case ({adr_i[4:2], 2'b00})
			`COD_ADDR_DIV_CTRL: rdata_d = {16'h0000, div_ctrl_q};
			`COD_ADDR_DRV_EN: rdata_d = {24'h000000, drv_en_q};
			`COD_ADDR_DRV_TYPE: rdata_d = {24'h000000, drv_type_q};
			`COD_ADDR_DRV_AMP: rdata_d = {24'h000000, drv_amp_q};
			`COD_ADDR_STATUS: rdata_d = {28'h0000000, type_bad, ratio_bad, enabled,
				driver_power_down_o};
			default: hit_d = 1'b0;
		endcase
	end

	// ----------------------------------------
	// write path and bus answer
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_ctrl_q <= `COD_RST_DIV_CTRL; // RULE_02
			drv_en_q <= `COD_RST_DRV_EN;
			drv_type_q <= `COD_RST_DRV_TYPE; // RULE_09
			drv_amp_q <= `COD_RST_DRV_AMP; // RULE_13
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req && hit_d;
			err_o <= req && !hit_d;
			dat_o <= (req && hit_d && !we_i) ? rdata_d : 32'h00000000;
			if (req && hit_d && we_i) begin
				case ({adr_i[4:2], 2'b00})
					`COD_ADDR_DIV_CTRL: begin
						if (sel_i[0])
							div_ctrl_q[7:0] <= dat_i[7:0];
						if (sel_i[1])
							div_ctrl_q[15:8] <= dat_i[15:8] & DIV_WMASK[15:8];
					end
					`COD_ADDR_DRV_EN: begin
						if (sel_i[0])
							drv_en_q <= dat_i[7:0] & `COD_WMASK_DRV_EN;
					end
					`COD_ADDR_DRV_TYPE: begin
						if (sel_i[0])
							drv_type_q <= dat_i[7:0] & `COD_WMASK_DRV_TYPE;
					end
					`COD_ADDR_DRV_AMP: begin
						if (sel_i[0])
							drv_amp_q <= dat_i[7:0] & `COD_WMASK_DRV_AMP;
					end
					default: begin
						drv_en_q <= drv_en_q;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// driver state
	// ----------------------------------------
	assign ratio_bad = div_ctrl_q[`COD_DIV_RATIO_MSB:0] < `COD_DIV_MIN; // RULE_01
	assign ratio_eff = ratio_bad ? `COD_DIV_MIN : div_ctrl_q[`COD_DIV_RATIO_MSB:0]; // RULE_01
	assign type_bad = drv_type_q[`COD_TYPE_MSB:`COD_TYPE_LSB] == `COD_TYPE_RSVD; // RULE_10
	assign enabled = !drv_en_q[`COD_DRV_DISABLE_BIT] && !ext_sync_q; // RULE_04

	cod_divider #(
		.RATIO_W(14)
	) u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.regulator_on_i(div_ctrl_q[`COD_DIV_REG_ON_BIT]),
		.ratio_i(ratio_eff),
		.div_clk_o(div_clk)
	);

	cod_pin_mux u_mux (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clk_in_i(div_clk),
		.enabled_i(enabled),
		.power_down_i(drv_en_q[`COD_DRV_PD_BIT]),
		.drv_type_i(drv_type_q[`COD_TYPE_MSB:`COD_TYPE_LSB]),
		.dis_state_i(drv_en_q[`COD_DRV_DIS_STATE_MSB:`COD_DRV_DIS_STATE_LSB]),
		.cmos_arr_i(drv_type_q[`COD_CMOS_MSB:`COD_CMOS_LSB]),
		.true_o(pin_t),
		.true_oe_o(pin_t_oe),
		.comp_o(pin_c),
		.comp_oe_o(pin_c_oe)
	);

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			clk_out_true_o <= 1'b0;
			clk_out_true_oe_o <= 1'b0;
			clk_out_comp_o <= 1'b0;
			clk_out_comp_oe_o <= 1'b0;
			divider_regulator_on_o <= 1'b1;
			driver_bias_on_o <= 1'b1;
			hcsl_term_on_o <= 1'b1;
			low_swing_common_level_o <= 2'h2;
			swing_code_o <= 4'hb;
			lvds_amp_high_o <= 1'b0;
			driver_power_down_o <= 1'b0;
		end else begin
			clk_out_true_o <= pin_t; // RULE_03
			clk_out_comp_o <= pin_c; // RULE_06
			clk_out_true_oe_o <= pin_t_oe; // RULE_05
			clk_out_comp_oe_o <= pin_c_oe; // RULE_05
			driver_power_down_o <= drv_en_q[`COD_DRV_PD_BIT]; // RULE_05
			divider_regulator_on_o <= div_ctrl_q[`COD_DIV_REG_ON_BIT]; // RULE_02
			driver_bias_on_o <= drv_type_q[`COD_BIAS_BIT]; // RULE_09
			hcsl_term_on_o <= drv_type_q[`COD_TERM_BIT] &&
				drv_type_q[`COD_TYPE_MSB:`COD_TYPE_LSB] == `COD_TYPE_HCSL; // RULE_08
			low_swing_common_level_o <= drv_type_q[`COD_CM_MSB:`COD_CM_LSB]; // RULE_07
			swing_code_o <= drv_amp_q[`COD_SWING_MSB:`COD_SWING_LSB]; // RULE_11
			lvds_amp_high_o <= drv_amp_q[`COD_LVDS_AMP_BIT] &&
				drv_type_q[`COD_TYPE_MSB:`COD_TYPE_LSB] == `COD_TYPE_LVDS; // RULE_12
		end
	end
endmodule

// >>> cod_top_props.sv
// assertions on the clock output config bank ports
`timescale 1ns/1ps
module cod_top_props (
	// clock, reset and bus
	input logic clk_i,
	input logic rst_i,
	input logic cyc_i,
	input logic stb_i,
	input logic we_i,
	input logic [4:0] adr_i,
	input logic [3:0] sel_i,
	input logic [31:0] dat_i,
	input logic [31:0] dat_o,
	input logic ack_o,
	input logic err_o,
	// driver side
	input logic clk_out_true_oe_o,
	input logic clk_out_comp_oe_o,
	input logic divider_regulator_on_o,
	input logic [3:0] swing_code_o,
	input logic driver_power_down_o
);
	wire take = cyc_i && stb_i && !ack_o && !err_o;
	wire en_wr = take && we_i && adr_i == 5'h04 && sel_i[0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	reset_vals_a: assert property ($fell(rst_i) |-> divider_regulator_on_o && swing_code_o == 4'hb)
		else $error("field mirror wrong after reset");
	ack_latency_a: assert property (take |=> ack_o != err_o)
		else $error("no single answer one cycle after request");
	ack_pulse_a: assert property ((ack_o || err_o) |=> !ack_o && !err_o)
		else $error("answer held longer than one cycle");
	err_unmap_a: assert property (take && adr_i[4:2] > 3'h4 |=> err_o)
		else $error("unmapped access not refused");
	rd_zero_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data not zero outside ack");
	pd_set_a: assert property (en_wr && dat_i[0] |-> ##[1:3] driver_power_down_o)
		else $error("power down not applied");
	pd_clear_a: assert property (en_wr && !dat_i[0] |-> ##[1:3] !driver_power_down_o)
		else $error("power down not released");
	pd_tristate_a: assert property (driver_power_down_o && $past(driver_power_down_o, 3)
		|-> !clk_out_true_oe_o && !clk_out_comp_oe_o)
		else $error("pins driven while powered down");
endmodule
bind cod_top cod_top_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .clk_out_true_oe_o(clk_out_true_oe_o),
	.clk_out_comp_oe_o(clk_out_comp_oe_o), .divider_regulator_on_o(divider_regulator_on_o),
	.swing_code_o(swing_code_o), .driver_power_down_o(driver_power_down_o));

// >>> tb_top.sv
// self-checking bench for the clock output config bank
`timescale 1ns/1ps
`define CHK(g, x) begin \
	n_compared++; \
	if ((g) !== (x)) begin \
		num_errors++; \
		$display("unexpected at %0t: got %h exp %h", $time, g, x); \
	end \
end
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [4:0] adr_i = 5'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic ext_disable_i = 1'b0;
	wire [31:0] dat_o;
	wire ack_o, err_o, t_o, t_oe, c_o, c_oe, reg_on, bias_on, term_on, amp_hi, pd_o;
	wire [1:0] cm_o;
	wire [3:0] sw_o;
	int num_errors = 0;
	int n_compared = 0;
	int sm, op, th, ch, te, ce;
	logic [31:0] q;
	logic e;
	always #5 clk_i = ~clk_i;
	cod_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.err_o(err_o), .ext_disable_i(ext_disable_i), .clk_out_true_o(t_o),
		.clk_out_true_oe_o(t_oe), .clk_out_comp_o(c_o), .clk_out_comp_oe_o(c_oe),
		.divider_regulator_on_o(reg_on), .driver_bias_on_o(bias_on), .hcsl_term_on_o(term_on),
		.low_swing_common_level_o(cm_o), .swing_code_o(sw_o), .lvds_amp_high_o(amp_hi),
		.driver_power_down_o(pd_o));
	// ----------------------------------------
	// bus and pin tasks
	// ----------------------------------------
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1 && err_o !== 1'b1);
		q = dat_o;
		e = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] x);
		wb(1'b0, a, 32'h0);
		`CHK(q, x)
	endtask
	task automatic pins(input logic [7:0] m, input logic [7:0] x);
		{sm, op, th, ch, te, ce} = '0;
		repeat (6) @(posedge clk_i);
		repeat (40) begin
			@(posedge clk_i);
			sm += (t_o === c_o);
			op += (t_o !== c_o);
			th += (t_o === 1'b1);
			ch += (c_o === 1'b1);
			te += (t_oe === 1'b1);
			ce += (c_oe === 1'b1);
		end
		`CHK({sm > 0, op > 0, th > 0, ch > 0, th < 40, ch < 40, te == 40, ce == 40} & m, x)
	endtask
	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(5'h00, 32'h8069);
		rd(5'h04, 32'h0);
		rd(5'h08, 32'h6c);
		rd(5'h0c, 32'hb4);
		`CHK({reg_on, bias_on, term_on, cm_o, sw_o, amp_hi, pd_o}, 11'h7ac)
		wb(1'b1, 5'h00, 32'hffff);
		rd(5'h00, 32'hbfff);
		wb(1'b1, 5'h00, 32'h000a);
		rd(5'h10, 32'h2);
		`CHK(reg_on, 1'b0)
		wb(1'b1, 5'h00, 32'h800a);
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, 5'h08, 32'h2f + 32'(k) * 64);
			pins(8'hff, 32'hdfef7fbf >> (k * 8));
		end
		wb(1'b1, 5'h08, 32'h6c);
		for (int s = 0; s < 4; s++) begin
			wb(1'b1, 5'h04, 32'(s) * 4 + 2);
			pins(s == 2 ? 8'h03 : 8'hff, 32'h7f005b8f >> (s * 8));
		end
		wb(1'b1, 5'h04, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, 5'h08, 32'h4e + 32'(i) * 16);
			rd(5'h08, 32'h4e + 32'(i) * 16);
			`CHK(cm_o, 2'(i))
		end
		ext_disable_i <= 1'b1;
		pins(8'hff, 8'h5b);
		ext_disable_i <= 1'b0;
		pins(8'hff, 8'h7f);
		wb(1'b1, 5'h0c, 32'h5c);
		rd(5'h0c, 32'h5c);
		`CHK({sw_o, amp_hi}, 5'h0b)
		wb(1'b1, 5'h04, 32'hd);
		pins(8'h03, 8'h00);
		`CHK(pd_o, 1'b1)
		wb(1'b1, 5'h08, 32'h64);
		rd(5'h04, 32'hd);
		`CHK({term_on, bias_on, amp_hi}, 3'b010)
		wb(1'b1, 5'h14, 32'hff);
		`CHK(e, 1'b1)
		wb(1'b1, 5'h04, 32'hff);
		rd(5'h04, 32'h0f);
		give_verdict();
	end
endmodule
